// *** rtl/pcs_pkg.sv ***
// Package of constants for the program counter, return stack and indirect unit
package pcs_pkg;
  localparam int PC_WIDTH = 13;
  localparam int STACK_DEPTH = 8;
  localparam int STACK_PTR_WIDTH = 3;
  localparam int DATA_WIDTH = 8;
  localparam int JUMP_FIELD_WIDTH = 11;
  localparam int IND_ADDR_WIDTH = 9;
  localparam logic [PC_WIDTH-1:0] PC_RESET = 13'h0000;
  localparam logic [STACK_PTR_WIDTH-1:0] SP_RESET = 3'h0;
  localparam logic [DATA_WIDTH-1:0] LATCH_RESET = 8'h00;
  localparam logic [DATA_WIDTH-1:0] POINTER_RESET = 8'h00;
  localparam logic [DATA_WIDTH-1:0] IND_SELF_READ = 8'h00;
  localparam int LATCH_FULL_MSB = 4;
  localparam int LATCH_PAGE_LSB = 3;
  localparam int BANK_BIT_POS = 7;
  // AXI4-Lite register byte offsets
  localparam logic [7:0] REG_PC_LOW = 8'h00;
  localparam logic [7:0] REG_PC_LATCH = 8'h04;
  localparam logic [7:0] REG_POINTER = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_PC_FULL = 8'h10;
  localparam logic [7:0] REG_IND_ADDR = 8'h14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    PCS_OP_NONE, PCS_OP_STEP, PCS_OP_JUMP, PCS_OP_CALL, PCS_OP_INTR, PCS_OP_RETURN
  } pcs_op_type;
endpackage

// *** rtl/pcs_return_stack.sv ***
// Circular return stack with a hidden pointer
`timescale 1ns/10ps
module pcs_return_stack
  import pcs_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH,
  parameter int PTR_W = STACK_PTR_WIDTH,
  parameter int WIDTH = PC_WIDTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Stack operations
  input wire logic push,
  input wire logic pop,
  input wire logic [WIDTH-1:0] pushData,
  output logic [WIDTH-1:0] topData
);
  logic [WIDTH-1:0] entries [DEPTH];
  logic [PTR_W-1:0] stackPtr;
  logic [PTR_W-1:0] popPtr;

  // Pointer wraps silently, no overflow or underflow flag exists
  assign popPtr = stackPtr - PTR_W'(1); // RQ12 RQ13
  assign topData = entries[popPtr];

  always_ff @(posedge mclk) begin
    if (srst) begin
      stackPtr <= SP_RESET;
    end else if (push) begin
      entries[stackPtr] <= pushData; // RQ7 RQ12
      stackPtr <= stackPtr + PTR_W'(1);
    end else if (pop) begin
      stackPtr <= popPtr; // RQ13
    end
  end
endmodule

// *** rtl/pcs_indirect_port.sv ***
// Indirect data address former and self-reference guard
`timescale 1ns/10ps
module pcs_indirect_port
  import pcs_pkg::*;
(
  // Pointer and bank
  input wire logic [DATA_WIDTH-1:0] filePointer,
  input wire logic bankSelect,
  input wire logic selfAddressed,
  // Data memory side
  input wire logic indRead,
  input wire logic indWrite,
  input wire logic [DATA_WIDTH-1:0] memReadData,
  output logic [IND_ADDR_WIDTH-1:0] memAddr,
  output logic memWrite,
  output logic [DATA_WIDTH-1:0] indReadData
);
  assign memAddr = {bankSelect, filePointer}; // RQ17 RQ18
  // Writing through the port onto itself stores nothing
  assign memWrite = indWrite & ~selfAddressed; // RQ14 RQ16
  assign indReadData = (indRead & ~selfAddressed) ? memReadData : IND_SELF_READ; // RQ15
endmodule

// *** rtl/pcs_program_flow.sv ***
// Program counter, return stack and indirect addressing unit with AXI4-Lite view
//
// Behaviour
// RQ1 - Program counter is thirteen bits wide
// RQ2 - Low byte readable/writable, upper bits via latch
// RQ3 - Any reset clears whole program counter
// RQ4 - Low-byte write loads upper from latch 4:0
// RQ5 - Jump/call takes top two bits from latch 4:3
// RQ6 - Jump/call takes bits 10:0 from instruction
// RQ7 - Eight entry thirteen bit hardware return stack
// RQ8 - Stack pointer hidden from software
// RQ9 - Push on call and interrupt vectoring
// RQ10 - Pop on return, literal return, interrupt return
// RQ11 - Push and pop leave latch unchanged
// RQ12 - Stack wraps circularly, ninth push overwrites first
// RQ13 - No overflow or underflow flags
// RQ14 - Indirect port accesses pointer-selected location
// RQ15 - Self-addressed indirect read returns zero
// RQ16 - Self-addressed indirect write stores nothing
// RQ17 - Nine bit address: bank bit plus pointer
// RQ18 - Bank bit is address most significant bit
`timescale 1ns/10ps
module pcs_program_flow
  import pcs_pkg::*;
#(
  parameter int PCW = PC_WIDTH,
  parameter logic [DATA_WIDTH-1:0] IND_PORT_ADDR = 8'h00
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Core execution interface
  input wire logic [2:0] coreOp,
  input wire logic [JUMP_FIELD_WIDTH-1:0] jumpTarget,
  input wire logic [PCW-1:0] vectorAddr,
  input wire logic pcLowWrite,
  input wire logic [DATA_WIDTH-1:0] pcLowData,
  input wire logic latchWrite,
  input wire logic [DATA_WIDTH-1:0] latchData,
  input wire logic pointerWrite,
  input wire logic [DATA_WIDTH-1:0] pointerData,
  input wire logic bankWrite,
  input wire logic bankData,
  output logic [PCW-1:0] progCounter,
  // Indirect data port
  input wire logic indRead,
  input wire logic indWrite,
  input wire logic [DATA_WIDTH-1:0] memReadData,
  output logic [IND_ADDR_WIDTH-1:0] memAddr,
  output logic memWrite,
  output logic [DATA_WIDTH-1:0] indReadData,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  pcs_op_type op;
  logic [PCW-1:0] pc;
  logic [PCW-1:0] next_pc;
  logic [DATA_WIDTH-1:0] pcLatch;
  logic [DATA_WIDTH-1:0] filePointer;
  logic bankSelect;
  logic [PCW-1:0] stackTop;
  logic push;
  logic pop;
  logic [PCW-1:0] lowWriteTarget;
  logic [PCW-1:0] jumpFull;

  // Write channel holding registers
  logic awHeld;
  logic wHeld;
  logic [7:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic [7:0] rAddrSel;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic busWrite;
  logic wrHit;
  logic busPcLow;
  logic busLatch;
  logic busPointer;
  logic busStatus;
  logic bDone;
  // One hit per register offset, write side then read side
  logic awPcLow;
  logic awLatch;
  logic awPointer;
  logic awStatus;
  logic awPcFull;
  logic awIndAddr;
  logic arPcLow;
  logic arLatch;
  logic arPointer;
  logic arStatus;
  logic arPcFull;
  logic arIndAddr;
  logic wrLowByte;
  logic rdHit;
  logic swPcLow;
  logic swLatch;
  logic swPointer;
  logic swBank;
  logic [DATA_WIDTH-1:0] swPcLowData;
  logic [DATA_WIDTH-1:0] swLatchData;
  logic [DATA_WIDTH-1:0] swPointerData;
  logic swBankData;
  logic selfAddressed;

  // Codes six and seven fall into the idle branch
  assign op = pcs_op_type'(coreOp);
  assign progCounter = pc; // RQ1

  // Bus write decode, taken only when both halves are held
  assign awPcLow = (awAddr == REG_PC_LOW);
  assign awLatch = (awAddr == REG_PC_LATCH);
  assign awPointer = (awAddr == REG_POINTER);
  assign awStatus = (awAddr == REG_STATUS);
  assign awPcFull = (awAddr == REG_PC_FULL);
  assign awIndAddr = (awAddr == REG_IND_ADDR);
  assign busWrite = awHeld & wHeld & ~s_axi_bvalid;
  // Only byte lane zero carries register bits
  assign wrLowByte = wStrb[0];
  assign busPcLow = busWrite & wrLowByte & awPcLow;
  assign busLatch = busWrite & wrLowByte & awLatch;
  assign busPointer = busWrite & wrLowByte & awPointer;
  assign busStatus = busWrite & wrLowByte & awStatus;
  // Read-only offsets still answer OKAY so software can probe them
  assign wrHit = awPcLow | awLatch | awPointer | awStatus | awPcFull | awIndAddr;

  // Core writes take priority over the bus in the same cycle
  assign swPcLow = pcLowWrite | busPcLow;
  assign swPcLowData = pcLowWrite ? pcLowData : wData[DATA_WIDTH-1:0];
  assign swLatch = latchWrite | busLatch;
  assign swLatchData = latchWrite ? latchData : wData[DATA_WIDTH-1:0];
  assign swPointer = pointerWrite | busPointer;
  assign swPointerData = pointerWrite ? pointerData : wData[DATA_WIDTH-1:0];
  assign swBank = bankWrite | busStatus;
  assign swBankData = bankWrite ? bankData : wData[BANK_BIT_POS];

  // Program counter sources
  assign lowWriteTarget = {pcLatch[LATCH_FULL_MSB:0], swPcLowData}; // RQ2 RQ4
  assign jumpFull = {pcLatch[LATCH_FULL_MSB:LATCH_PAGE_LSB], jumpTarget}; // RQ5 RQ6
  assign push = (op == PCS_OP_CALL) || (op == PCS_OP_INTR); // RQ9
  assign pop = (op == PCS_OP_RETURN); // RQ10

  always_comb begin
    next_pc = pc;
    case (op)
      PCS_OP_STEP: begin
        // Wraps at the top of program space
        next_pc = pc + PCW'(1);
      end
      PCS_OP_JUMP, PCS_OP_CALL: begin
        next_pc = jumpFull; // RQ5 RQ6
      end
      PCS_OP_INTR: begin
        next_pc = vectorAddr;
      end
      PCS_OP_RETURN: begin
        next_pc = stackTop; // RQ10
      end
      default: begin
        next_pc = pc;
      end
    endcase
    // A low-byte write overrides sequencing, as a computed jump
    if (swPcLow) begin
      next_pc = lowWriteTarget; // RQ4
    end
  end

  // Every reset source arrives here as srst
  always_ff @(posedge mclk) begin
    if (srst) begin
      pc <= PC_RESET; // RQ3
    end else begin
      pc <= next_pc;
    end
  end

  // Latch is only touched by explicit writes, never by stack traffic
  always_ff @(posedge mclk) begin
    if (srst) begin
      pcLatch <= LATCH_RESET;
    end else if (swLatch) begin
      pcLatch <= swLatchData; // RQ11
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      filePointer <= POINTER_RESET;
    end else if (swPointer) begin
      filePointer <= swPointerData; // RQ14
    end
  end

  // Bank bit lives in the status view at a fixed position
  always_ff @(posedge mclk) begin
    if (srst) begin
      bankSelect <= 1'b0;
    end else if (swBank) begin
      bankSelect <= swBankData; // RQ17
    end
  end

  // Return address pushed is the current counter value, not incremented first
  pcs_return_stack #(
    .DEPTH(STACK_DEPTH),
    .PTR_W(STACK_PTR_WIDTH),
    .WIDTH(PCW)
  ) u_stack (
    .mclk(mclk),
    .srst(srst),
    .push(push), // RQ8 RQ9
    .pop(pop & ~push),
    .pushData(pc),
    .topData(stackTop)
  );

  // Only bank zero holds the port's own address
  assign selfAddressed = (bankSelect == 1'b0) && (filePointer == IND_PORT_ADDR);

  pcs_indirect_port u_ind (
    .filePointer(filePointer),
    .bankSelect(bankSelect), // RQ17
    .selfAddressed(selfAddressed), // RQ15 RQ16
    .indRead(indRead),
    .indWrite(indWrite),
    .memReadData(memReadData),
    .memAddr(memAddr), // RQ14
    .memWrite(memWrite),
    .indReadData(indReadData)
  );

  // AXI4-Lite write path; address and data accepted in either order
  assign s_axi_awready = ~awHeld;
  assign s_axi_wready = ~wHeld;
  // Both halves stay held until the response is taken, so one write at a time
  assign bDone = s_axi_bvalid & s_axi_bready;

  always_ff @(posedge mclk) begin
    if (srst) begin
      awHeld <= 1'b0;
      awAddr <= 8'h00;
    end else if (s_axi_awvalid && !awHeld) begin
      awHeld <= 1'b1;
      awAddr <= s_axi_awaddr;
    end else if (bDone) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      wHeld <= 1'b0;
      wData <= 32'h00000000;
      wStrb <= 4'h0;
    end else if (s_axi_wvalid && !wHeld) begin
      wHeld <= 1'b1;
      wData <= s_axi_wdata;
      wStrb <= s_axi_wstrb;
    end else if (bDone) begin
      wHeld <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (busWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
    end else if (bDone) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // AXI4-Lite read path; the stack pointer has no address at all
  assign s_axi_arready = ~s_axi_rvalid;
  assign rAddrSel = s_axi_araddr;
  assign arPcLow = (rAddrSel == REG_PC_LOW);
  assign arLatch = (rAddrSel == REG_PC_LATCH);
  assign arPointer = (rAddrSel == REG_POINTER);
  assign arStatus = (rAddrSel == REG_STATUS);
  assign arPcFull = (rAddrSel == REG_PC_FULL);
  assign arIndAddr = (rAddrSel == REG_IND_ADDR);
  assign rdHit = arPcLow | arLatch | arPointer | arStatus | arPcFull | arIndAddr;
  assign next_rresp = rdHit ? RESP_OKAY : RESP_SLVERR;

  // Unmapped offsets read zero; no offset reaches the stack pointer
  always_comb begin
    next_rdata = 32'h00000000; // RQ8
    if (arPcLow) begin
      next_rdata = {24'h000000, pc[DATA_WIDTH-1:0]}; // RQ2
    end else if (arLatch) begin
      next_rdata = {24'h000000, pcLatch};
    end else if (arPointer) begin
      next_rdata = {24'h000000, filePointer};
    end else if (arStatus) begin
      next_rdata = {24'h000000, bankSelect, 7'h00};
    end else if (arPcFull) begin
      next_rdata = {19'h0, pc};
    end else if (arIndAddr) begin
      next_rdata = {23'h0, memAddr};
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// *** tb/pcs_program_flow_asserts.sv ***
// Port checks for the program flow unit
`timescale 1ns/10ps
module pcs_program_flow_asserts
  import pcs_pkg::*;
#(
  parameter int PCW = PC_WIDTH,
  parameter logic [DATA_WIDTH-1:0] IND_PORT_ADDR = 8'h00
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Core side
  input wire logic [2:0] coreOp,
  input wire logic [JUMP_FIELD_WIDTH-1:0] jumpTarget,
  input wire logic [PCW-1:0] vectorAddr,
  input wire logic pcLowWrite,
  input wire logic [DATA_WIDTH-1:0] pcLowData,
  input wire logic latchWrite,
  input wire logic [DATA_WIDTH-1:0] latchData,
  input wire logic pointerWrite,
  input wire logic [DATA_WIDTH-1:0] pointerData,
  input wire logic bankWrite,
  input wire logic bankData,
  input wire logic [PCW-1:0] progCounter,
  input wire logic indRead,
  input wire logic indWrite,
  input wire logic [DATA_WIDTH-1:0] memReadData,
  input wire logic [IND_ADDR_WIDTH-1:0] memAddr,
  input wire logic memWrite,
  input wire logic [DATA_WIDTH-1:0] indReadData
);
  // Follows core writes only, so bus writes to the latch are not covered here
  logic [DATA_WIDTH-1:0] latchCopy;
  always_ff @(posedge mclk) begin
    if (srst) begin
      latchCopy <= LATCH_RESET;
    end else if (latchWrite) begin
      latchCopy <= latchData;
    end
  end
  wire logic selfHit = memAddr == {1'b0, IND_PORT_ADDR};
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  pc_reset_a: assert property ($fell(srst) |-> progCounter == PC_RESET)
    else $error("pc not cleared");
  low_load_a: assert property (pcLowWrite |=> progCounter ==
    {$past(latchCopy[4:0]), $past(pcLowData)}) else $error("low write load wrong");
  jump_load_a: assert property (!pcLowWrite && coreOp inside {3'h2, 3'h3} |=>
    progCounter == {$past(latchCopy[4:3]), $past(jumpTarget)}) else $error("jump load wrong");
  vector_load_a: assert property (!pcLowWrite && coreOp == 3'h4 |=>
    progCounter == $past(vectorAddr)) else $error("vector load wrong");
  ptr_addr_a: assert property (pointerWrite |=> memAddr[7:0] == $past(pointerData))
    else $error("pointer not in address");
  bank_addr_a: assert property (bankWrite |=> memAddr[8] == $past(bankData))
    else $error("bank not address top bit");
  self_write_a: assert property (memWrite == (indWrite && !selfHit))
    else $error("indirect write gating wrong");
  self_read_a: assert property (indRead |-> indReadData ==
    (selfHit ? IND_SELF_READ : memReadData)) else $error("indirect read wrong");
endmodule
bind pcs_program_flow pcs_program_flow_asserts #(.PCW(PCW), .IND_PORT_ADDR(IND_PORT_ADDR))
  u_pcs_program_flow_asserts (.mclk, .srst, .coreOp, .jumpTarget, .vectorAddr, .pcLowWrite,
  .pcLowData, .latchWrite, .latchData, .pointerWrite, .pointerData, .bankWrite, .bankData,
  .progCounter, .indRead, .indWrite, .memReadData, .memAddr, .memWrite, .indReadData);

// *** tb/pcs_data_mem.sv ***
// Data memory model behind the indirect port
`timescale 1ns/10ps
module pcs_data_mem
  import pcs_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Memory port
  input wire logic [IND_ADDR_WIDTH-1:0] memAddr,
  input wire logic memWrite,
  input wire logic [DATA_WIDTH-1:0] wrData,
  output logic [DATA_WIDTH-1:0] memReadData
);
  // Left unset so a read of an unwritten cell shows unknown
  logic [DATA_WIDTH-1:0] mem [2**IND_ADDR_WIDTH];
  assign memReadData = mem[memAddr];
  always @(posedge mclk) begin
    if (memWrite) begin
      mem[memAddr] <= wrData;
    end
  end
endmodule

// *** tb/pcs_program_flow_tb.sv ***
// Testbench for the program flow unit
`timescale 1ns/10ps
module pcs_program_flow_tb;
  import pcs_pkg::*;
  logic mclk, srst, pcLowWrite, latchWrite, pointerWrite, bankWrite, bankData;
  logic indRead, indWrite, memWrite;
  logic [2:0] coreOp;
  logic [10:0] jumpTarget;
  logic [12:0] vectorAddr, progCounter;
  logic [7:0] pcLowData, latchData, pointerData, memReadData, indReadData, wrData;
  logic [8:0] memAddr;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int num_errors = 0;
  int compares = 0;
  pcs_program_flow u_pcs_program_flow (.mclk, .srst, .coreOp, .jumpTarget, .vectorAddr,
    .pcLowWrite, .pcLowData, .latchWrite, .latchData, .pointerWrite, .pointerData,
    .bankWrite, .bankData, .progCounter, .indRead, .indWrite, .memReadData, .memAddr,
    .memWrite, .indReadData, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  pcs_data_mem u_pcs_data_mem (.mclk, .memAddr, .memWrite, .wrData, .memReadData);
  initial begin
    mclk = 0;
    forever #25 mclk = ~mclk;
  end
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask
  task automatic finish_test();
    if (num_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic op(input logic [2:0] o, input logic [10:0] t);
    @(posedge mclk);
    coreOp <= o;
    jumpTarget <= t;
    @(posedge mclk);
    coreOp <= PCS_OP_NONE;
    #1;
  endtask
  // Kind 0 pc low, 1 latch, 2 pointer, 3 bank
  task automatic poke(input int k, input logic [7:0] d);
    @(posedge mclk);
    {pcLowData, latchData, pointerData, bankData} <= {d, d, d, d[0]};
    {pcLowWrite, latchWrite, pointerWrite, bankWrite} <= 4'h8 >> k;
    @(posedge mclk);
    {pcLowWrite, latchWrite, pointerWrite, bankWrite} <= 4'h0;
    #1;
  endtask
  task automatic axi_read(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge mclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    {aw, w} = 2'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'h3};
    while (!(aw && w)) begin
      @(posedge mclk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1;
        s_axi_awvalid <= 0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1;
        s_axi_wvalid <= 0;
      end
    end
    do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    #1;
  endtask
  task automatic t_low();
    check("pc reset", PC_RESET, progCounter);
    axi_read(8'h40);
    check("unmapped", RESP_SLVERR, rs);
    poke(1, 8'hEF);
    poke(0, 8'hAB);
    check("pc low write", 13'h0FAB, progCounter);
    axi_read(REG_PC_LOW);
    check("pc low read", 32'hAB, rd);
    axi_write(REG_PC_FULL, 32'h0);
    axi_read(REG_PC_FULL);
    check("pc full", 32'h0FAB, rd);
    op(PCS_OP_JUMP, 11'h123);
    check("jump", 13'h0923, progCounter);
    op(PCS_OP_STEP, 11'h0);
    check("step", 13'h0924, progCounter);
  endtask
  task automatic t_stack();
    logic [12:0] pushed [9];
    for (int i = 0; i < 9; i++) begin
      pushed[i] = progCounter;
      op(PCS_OP_CALL, 11'h100 + 11'(i));
      check("call", {2'h1, 11'h100 + 11'(i)}, progCounter);
    end
    for (int i = 8; i > 0; i--) begin
      op(PCS_OP_RETURN, 11'h0);
      check("pop", pushed[i], progCounter);
    end
    op(PCS_OP_RETURN, 11'h0);
    check("wrap pop", pushed[8], progCounter);
    axi_read(REG_PC_LATCH);
    check("latch", 32'hEF, rd);
    op(PCS_OP_INTR, 11'h0);
    check("vector", vectorAddr, progCounter);
    op(PCS_OP_RETURN, 11'h0);
    check("intr return", pushed[8], progCounter);
  endtask
  task automatic t_reset();
    @(posedge mclk);
    srst <= 1;
    repeat (3) @(posedge mclk);
    srst <= 0;
    @(posedge mclk);
    #1;
    check("pc mid reset", PC_RESET, progCounter);
    axi_read(REG_PC_LATCH);
    check("latch reset", LATCH_RESET, rd);
  endtask
  task automatic t_ind();
    poke(2, 8'h55);
    poke(3, 8'h01);
    check("ind addr", 9'h155, memAddr);
    {wrData, indWrite} <= {8'h3C, 1'b1};
    @(posedge mclk);
    {indWrite, indRead} <= 2'h1;
    #1;
    check("ind read", 8'h3C, indReadData);
    indRead <= 1'b0;
    poke(3, 8'h00);
    axi_write(REG_POINTER, 32'h0);
    indRead <= 1'b1;
    #1;
    check("self addr", 9'h000, memAddr);
    check("self read", IND_SELF_READ, indReadData);
    {indWrite, indRead} <= 2'h2;
    #1;
    check("self write", 1'b0, memWrite);
  endtask
  initial begin
    {srst, pcLowWrite, latchWrite, pointerWrite, bankWrite, bankData, indRead, indWrite} = 8'h80;
    {coreOp, jumpTarget, vectorAddr, pcLowData, latchData, pointerData, wrData} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_wstrb, s_axi_bready, s_axi_rready} = 6'h3F;
    vectorAddr = 13'h0004;
    repeat (3) @(posedge mclk);
    srst <= 0;
    @(posedge mclk);
    t_low();
    t_stack();
    t_reset();
    t_ind();
    finish_test();
  end
  initial begin
    repeat (3000) @(posedge mclk);
    num_errors++;
    finish_test();
  end
endmodule
